// *** pkg/scl_pkg.sv ***
// Function
// - Multidrop role per circuit, reset disabled
// - Master under primary adaption: full-duplex, signalling off
// - Slave: half-duplex, signalling off
// - Async or sync mode, sync after reset
// - DTE or DCE gender, DCE after reset
// - Duplex not selectable; full unless multidrop changes
// - RTS-to-CTS delay accepted only for slave
// - Delay 0 to 140 ms, 10 ms steps
// - DTR DSR RTS CTS DCD: on, off, follow
// - Async lead defaults per gender
// - Sync lead directions per gender and clocking
// - Sync mode: DTR and DSR unused
// - Sync DCE: CTS follows local RTS
// - Sync DCE: local RTS sent as DCD
// - Follow lead copies remote lead state
// - Following offered under primary and alternate digital adaption, not transparent
// - Alternate digital adaption: pairs in async, all used leads in sync
package scl_pkg;

   localparam int NUM_CIRC = 2;

   // Register map: each group holds one word per circuit.
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] LEAD_OFS = 8'h08;
   localparam logic [7:0] DELAY_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS = 8'h18;
   localparam logic [7:0] MAP_END = 8'h20;

   // Configuration word fields.
   localparam int CFG_ASYNC_BIT = 0;
   localparam int CFG_DTE_BIT = 1;
   localparam int CFG_ROLE_LSB = 2;
   localparam int CFG_RATE_LSB = 4;
   localparam int CFG_CLK_LSB = 6;
   localparam int CFG_W = 8;

   // Status word fields.
   localparam int STAT_PIN_LSB = 0;
   localparam int STAT_NET_LSB = 5;
   localparam int STAT_HALF_BIT = 10;
   localparam int STAT_SIG_BIT = 11;
   localparam int STAT_WAIT_BIT = 12;

   // RTS-to-CTS delay.
   localparam int DELAY_STEP_MS = 10;
   localparam int DELAY_MAX_MS = 140;
   localparam int CLK_KHZ = 250000;
   localparam logic [3:0] DELAY_MAX_STEPS = 4'(DELAY_MAX_MS / DELAY_STEP_MS);
   localparam logic [3:0] DELAY_RST = 4'h0;
   localparam int unsigned STEP_CYCLES_DEF = DELAY_STEP_MS * CLK_KHZ;

   typedef enum logic [1:0] {ROLE_DISABLED, ROLE_MASTER, ROLE_SLAVE} scl_role_e;
   typedef enum logic [1:0] {RATE_PRIMARY, RATE_ALT_DIGITAL, RATE_TRANSPARENT}
      scl_rate_e;
   typedef enum logic [1:0] {CLK_SLAVE, CLK_EXTERNAL, CLK_INTERNAL} scl_clk_e;
   typedef enum logic [1:0] {LEAD_OFF, LEAD_ON, LEAD_FOLLOW} scl_lead_e;

   typedef struct packed {
      logic dtr;
      logic dsr;
      logic rts;
      logic cts;
      logic dcd;
   } scl_leads_s;

   typedef struct packed {
      scl_lead_e dtr;
      scl_lead_e dsr;
      scl_lead_e rts;
      scl_lead_e cts;
      scl_lead_e dcd;
   } scl_lead_cfg_s;

   typedef struct packed {
      scl_clk_e clk_src;
      scl_rate_e rate;
      scl_role_e role;
      logic dte;
      logic async_mode;
   } scl_cfg_s;

   localparam scl_cfg_s CFG_RST = '{CLK_SLAVE, RATE_PRIMARY, ROLE_DISABLED,
                                    1'b0, 1'b0};

   // Leads that the attached equipment drives into the circuit.
   function automatic scl_leads_s lead_in_mask(scl_cfg_s c);
      scl_leads_s m;
      m = '0;
      if (c.async_mode && !c.dte) begin
         m.rts = 1'b1;
         m.dtr = 1'b1;
      end else if (c.async_mode) begin
         m.dcd = 1'b1;
         m.dsr = 1'b1;
      end else if (!c.dte) begin
         m.rts = 1'b1;
      end else if (c.clk_src != CLK_INTERNAL) begin
         m.dcd = 1'b1;
      end
      return m;
   endfunction

   // Leads that the circuit drives toward the attached equipment.
   function automatic scl_leads_s lead_out_mask(scl_cfg_s c);
      scl_leads_s m;
      m = '0;
      if (c.async_mode && !c.dte) begin
         m.cts = 1'b1;
         m.dsr = 1'b1;
      end else if (c.async_mode) begin
         m.rts = 1'b1;
         m.dtr = 1'b1;
      end else if (!c.dte) begin
         m.cts = 1'b1;
      end else begin
         m.rts = 1'b1;
      end
      return m;
   endfunction

   function automatic scl_lead_cfg_s lead_defaults(scl_cfg_s c);
      scl_lead_cfg_s d;
      scl_leads_s used;
      used = lead_in_mask(c) | lead_out_mask(c);
      d.dtr = used.dtr ? LEAD_FOLLOW : LEAD_OFF;
      d.dsr = used.dsr ? LEAD_FOLLOW : LEAD_OFF;
      d.rts = used.rts ? LEAD_FOLLOW : LEAD_OFF;
      d.cts = used.cts ? LEAD_FOLLOW : LEAD_OFF;
      d.dcd = used.dcd ? LEAD_FOLLOW : LEAD_OFF;
      if (c.async_mode && !c.dte) begin
         d.dsr = LEAD_ON;
      end
      if (c.async_mode && c.dte) begin
         d.dtr = LEAD_ON;
      end
      return d;
   endfunction

   // Leads allowed to follow the far end under the chosen rate adaption.
   function automatic scl_leads_s follow_ok(scl_cfg_s c);
      scl_leads_s m;
      m = '0;
      if (c.rate == RATE_PRIMARY) begin
         m = '1;
      end else if (c.rate == RATE_ALT_DIGITAL) begin
         if (!c.async_mode) begin
            m = lead_in_mask(c) | lead_out_mask(c);
         end else if (!c.dte) begin
            m.rts = 1'b1;
            m.cts = 1'b1;
         end else begin
            m.dcd = 1'b1;
            m.rts = 1'b1;
         end
      end
      return m;
   endfunction

endpackage

// *** src/scl_delay.sv ***
`timescale 1ns/10ps
// Delays the rising edge of a request by a whole number of steps.
module scl_delay #(
   parameter int unsigned STEP_CYCLES = scl_pkg::STEP_CYCLES_DEF
) (
   input wire logic pclk, // Bus clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic req, // Level to be delayed on its rise.
   input wire logic [3:0] steps, // Delay in steps.
   output logic grant, // Delayed level.
   output logic busy // Rise seen, delay still running.
);

   logic [31:0] cyc;
   logic [3:0] step_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc <= '0;
         step_cnt <= '0;
         grant <= 1'b0;
         busy <= 1'b0;
      end else if (!req) begin
         // Dropping the request releases the grant at once.
         cyc <= '0;
         step_cnt <= '0;
         grant <= 1'b0;
         busy <= 1'b0;
      end else if (!grant) begin
         busy <= 1'b1;
         if (step_cnt >= steps) begin
            grant <= 1'b1;
            busy <= 1'b0;
         end else if (cyc >= 32'(STEP_CYCLES - 1)) begin
            cyc <= '0;
            step_cnt <= step_cnt + 4'h1;
         end else begin
            cyc <= cyc + 32'h1;
         end
      end
   end

endmodule

// *** src/scl_lead.sv ***
`timescale 1ns/10ps
// Resolves the control leads of one circuit.
module scl_lead (
   input wire logic pclk, // Bus clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire scl_pkg::scl_cfg_s cfg, // Circuit configuration.
   input wire scl_pkg::scl_lead_cfg_s lead_cfg, // Per-lead settings.
   input wire logic sig_on, // Lead signalling enabled.
   input wire logic half, // Half-duplex in force.
   input wire scl_pkg::scl_leads_s pin, // Synchronised local leads.
   input wire scl_pkg::scl_leads_s net_rx, // Leads from the far end.
   input wire logic cts_delayed, // Local RTS after the delay.
   output scl_pkg::scl_leads_s pin_out, // Leads to equipment.
   output scl_pkg::scl_leads_s pin_oe, // Lead drive enables.
   output scl_pkg::scl_leads_s net_tx // Leads toward the far end.
);

   scl_pkg::scl_leads_s in_m;
   scl_pkg::scl_leads_s out_m;
   scl_pkg::scl_leads_s ok;
   scl_pkg::scl_leads_s src;
   scl_pkg::scl_leads_s next_out;
   scl_pkg::scl_leads_s next_tx;
   logic [9:0] set_bits;

   function automatic logic resolve(logic [1:0] s, logic allow, logic v);
      if (s == 2'(scl_pkg::LEAD_ON)) begin
         return 1'b1;
      end
      if (s == 2'(scl_pkg::LEAD_FOLLOW)) begin
         return allow & v;
      end
      return 1'b0;
   endfunction

   always_comb begin
      in_m = scl_pkg::lead_in_mask(cfg);
      out_m = scl_pkg::lead_out_mask(cfg);
      ok = scl_pkg::follow_ok(cfg) & {5{sig_on}};
      set_bits = lead_cfg;
      src = net_rx;
      if (!cfg.dte && (!cfg.async_mode || half)) begin
         src.cts = cts_delayed;
         // The local echo is not far-end signalling, so a slave with its
         // signalling off still gets its delayed CTS.
         ok.cts = 1'b1;
      end
      for (int i = 0; i < 5; i++) begin
         next_out[i] = out_m[i] & resolve(set_bits[2*i +: 2], ok[i], src[i]);
         next_tx[i] = in_m[i] & resolve(set_bits[2*i +: 2], ok[i], pin[i]);
      end
      if (!cfg.async_mode && !cfg.dte) begin
         next_tx.dcd = next_tx.rts;
         next_tx.rts = 1'b0;
      end
      if (!cfg.async_mode) begin
         next_out.dtr = 1'b0;
         next_out.dsr = 1'b0;
         next_tx.dtr = 1'b0;
         next_tx.dsr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= '0;
         pin_oe <= '0;
         net_tx <= '0;
      end else begin
         pin_out <= next_out;
         pin_oe <= out_m;
         net_tx <= next_tx;
      end
   end

endmodule

// *** src/scl_top.sv ***
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Dual-circuit serial lead control with an APB register file.
module scl_top #(
   parameter int unsigned STEP_CYCLES = scl_pkg::STEP_CYCLES_DEF
) (
   input wire logic pclk, // Bus clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error.
   input wire logic [1:0] connected, // Circuit is connected.
   input wire scl_pkg::scl_leads_s [1:0] pin_in, // Leads from equipment.
   output scl_pkg::scl_leads_s [1:0] pin_out, // Leads to equipment.
   output scl_pkg::scl_leads_s [1:0] pin_oe, // Lead drive enables.
   input wire scl_pkg::scl_leads_s [1:0] net_rx, // Far-end leads.
   output scl_pkg::scl_leads_s [1:0] net_tx, // Leads to the far end.
   output logic [1:0] half_duplex, // Circuit is half-duplex.
   output logic [1:0] signalling_on // Lead signalling enabled.
);

   scl_pkg::scl_leads_s [1:0] pin_meta;
   scl_pkg::scl_leads_s [1:0] pin_sync;
   scl_pkg::scl_cfg_s [1:0] cfg;
   scl_pkg::scl_lead_cfg_s [1:0] lead_cfg;
   logic [1:0][3:0] delay_steps;
   logic [1:0] cts_grant;
   logic [1:0] cts_busy;

   logic circ;
   logic [7:0] grp;
   logic mapped;
   logic bad_cfg;
   logic bad_delay;
   logic bad_wr;
   logic acc;
   logic wr_ok;
   scl_pkg::scl_cfg_s wr_cfg;
   logic [31:0] next_rdata;

   // Equipment leads come from another domain and pass two flops first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   // Address decode: low word bit picks the circuit, the rest the group.
   always_comb begin
      circ = paddr[2];
      grp = {paddr[7:3], 3'b000};
      mapped = (paddr < scl_pkg::MAP_END) && (paddr[1:0] == 2'b00);
      acc = psel & penable;
      wr_cfg = scl_pkg::scl_cfg_s'(pwdata[scl_pkg::CFG_W-1:0]);
      bad_cfg = (wr_cfg.role == scl_pkg::scl_role_e'(2'b11))
             || (wr_cfg.rate == scl_pkg::scl_rate_e'(2'b11))
             || (wr_cfg.clk_src == scl_pkg::scl_clk_e'(2'b11))
             || (pwdata[31:scl_pkg::CFG_W] != '0);
      bad_delay = (cfg[circ].role != scl_pkg::ROLE_SLAVE)
               || (pwdata[3:0] > scl_pkg::DELAY_MAX_STEPS)
               || (pwdata[31:4] != '0);
      bad_wr = 1'b0;
      if (!mapped) begin
         bad_wr = 1'b1;
      end else if (pwrite) begin
         unique case (grp)
            scl_pkg::CFG_OFS: bad_wr = bad_cfg | connected[circ];
            scl_pkg::LEAD_OFS: bad_wr = (pwdata[31:10] != '0);
            scl_pkg::DELAY_OFS: bad_wr = bad_delay | connected[circ];
            default: bad_wr = 1'b1;
         endcase
      end
      wr_ok = acc & pwrite & ~bad_wr;
   end

   // Every transfer completes in its first access cycle.
   assign pready = 1'b1;
   assign pslverr = acc & bad_wr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= {scl_pkg::NUM_CIRC{scl_pkg::CFG_RST}};
      end else if (wr_ok && grp == scl_pkg::CFG_OFS) begin
         cfg[circ] <= wr_cfg;
      end
   end

   // Lead settings; a new mode reloads its defaults so that no
   // lead keeps a setting that belongs to the old direction.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lead_cfg <= {scl_pkg::NUM_CIRC{scl_pkg::lead_defaults(
            scl_pkg::CFG_RST)}};
      end else if (wr_ok && grp == scl_pkg::CFG_OFS) begin
         lead_cfg[circ] <= scl_pkg::lead_defaults(wr_cfg);
      end else if (wr_ok && grp == scl_pkg::LEAD_OFS) begin
         for (int i = 0; i < 5; i++) begin
            // Reserved code 3 is taken as off.
            lead_cfg[circ][2*i +: 2] <= (pwdata[2*i +: 2] == 2'b11)
               ? 2'(scl_pkg::LEAD_OFF) : pwdata[2*i +: 2];
         end
      end
   end

   // Delay kept only for a slave.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_steps <= {scl_pkg::NUM_CIRC{scl_pkg::DELAY_RST}};
      end else if (wr_ok && grp == scl_pkg::DELAY_OFS) begin
         delay_steps[circ] <= pwdata[3:0];
      end else if (wr_ok && grp == scl_pkg::CFG_OFS &&
                   wr_cfg.role != scl_pkg::ROLE_SLAVE) begin
         delay_steps[circ] <= scl_pkg::DELAY_RST;
      end
   end

   // Duplex and signalling change only when the multidrop role is written.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_duplex <= '0;
         signalling_on <= '1;
      end else if (wr_ok && grp == scl_pkg::CFG_OFS) begin
         unique case (wr_cfg.role)
            scl_pkg::ROLE_MASTER: begin
               if (wr_cfg.rate == scl_pkg::RATE_PRIMARY) begin
                  half_duplex[circ] <= 1'b0;
                  signalling_on[circ] <= 1'b0;
               end
            end
            scl_pkg::ROLE_SLAVE: begin
               half_duplex[circ] <= 1'b1;
               signalling_on[circ] <= 1'b0;
            end
            default: begin
               half_duplex[circ] <= 1'b0;
               signalling_on[circ] <= 1'b1;
            end
         endcase
      end
   end

   // Read data is captured in the setup cycle so it is a flop output.
   always_comb begin
      next_rdata = '0;
      if (mapped) begin
         unique case (grp)
            scl_pkg::CFG_OFS: next_rdata[scl_pkg::CFG_W-1:0] = cfg[circ];
            scl_pkg::LEAD_OFS: next_rdata[9:0] = lead_cfg[circ];
            scl_pkg::DELAY_OFS: next_rdata[3:0] = delay_steps[circ];
            default: begin
               next_rdata[scl_pkg::STAT_PIN_LSB +: 5] = pin_out[circ];
               next_rdata[scl_pkg::STAT_NET_LSB +: 5] = net_tx[circ];
               next_rdata[scl_pkg::STAT_HALF_BIT] = half_duplex[circ];
               next_rdata[scl_pkg::STAT_SIG_BIT] = signalling_on[circ];
               next_rdata[scl_pkg::STAT_WAIT_BIT] = cts_busy[circ];
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   for (genvar c = 0; c < scl_pkg::NUM_CIRC; c++) begin : g_circ
      scl_delay #(
         .STEP_CYCLES(STEP_CYCLES)
      ) u_delay (
         .pclk(pclk),
         .presetn(presetn),
         .req(pin_sync[c].rts),
         .steps(delay_steps[c]),
         .grant(cts_grant[c]),
         .busy(cts_busy[c])
      );

      scl_lead u_lead (
         .pclk(pclk),
         .presetn(presetn),
         .cfg(cfg[c]),
         .lead_cfg(lead_cfg[c]),
         .sig_on(signalling_on[c]),
         .half(half_duplex[c]),
         .pin(pin_sync[c]),
         .net_rx(net_rx[c]),
         .cts_delayed(cts_grant[c]),
         .pin_out(pin_out[c]),
         .pin_oe(pin_oe[c]),
         .net_tx(net_tx[c])
      );
   end

endmodule

// *** test/scl_equip.sv ***
`timescale 1ns/10ps
module scl_equip (
   input wire logic pclk, // Clock.
   input wire scl_pkg::scl_leads_s [1:0] pin_oe, // Circuit drives lead.
   input wire scl_pkg::scl_leads_s [1:0] want, // Leads the bench raises.
   output scl_pkg::scl_leads_s [1:0] pin_in // Leads into the circuits.
);
   logic [9:0] tog = 10'h155;
   scl_pkg::scl_leads_s [1:0] req;
   always @(posedge pclk) begin
      tog <= ~tog;
   end
   always_comb begin
      req = want;
      if (want[0].rts) begin
         req[1].rts = 1'b0;
      end
   end
   // A lead the circuit drives carries noise here, so no stale level helps.
   assign pin_in = (req & ~pin_oe) | (tog & pin_oe);
endmodule

// *** test/scl_top_sva.sv ***
`timescale 1ns/10ps
module scl_top_sva #(
   parameter int unsigned STEP_CYCLES = scl_pkg::STEP_CYCLES_DEF
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Direction.
   input wire logic [7:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   input wire logic [1:0] connected, // Connected.
   input wire scl_pkg::scl_leads_s [1:0] pin_in, // Equipment leads.
   input wire scl_pkg::scl_leads_s [1:0] pin_out, // Leads out.
   input wire scl_pkg::scl_leads_s [1:0] pin_oe, // Drive enables.
   input wire scl_pkg::scl_leads_s [1:0] net_rx, // Far-end leads.
   input wire scl_pkg::scl_leads_s [1:0] net_tx, // Leads to far end.
   input wire logic [1:0] half_duplex, // Half duplex.
   input wire logic [1:0] signalling_on // Signalling.
);
   logic acc_w, wr_cfg, wr_lead, wr_dly;
   logic async0, dte0, frc, lvl;
   logic [1:0] up;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc_w = psel && penable && pwrite;
   assign wr_cfg = acc_w && !pslverr && paddr[7:3] == 5'h0;
   assign wr_lead = acc_w && !pslverr && paddr == scl_pkg::LEAD_OFS;
   assign wr_dly = acc_w && paddr[7:3] == 5'h2;
   // Outputs lag reset release by up to three edges (two sync flops, then the output flop), so checks wait for up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   // Shadow of circuit 0 mode and its CTS setting; code 3 reads as off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async0 <= 1'b0;
         dte0 <= 1'b0;
         frc <= 1'b0;
         lvl <= 1'b0;
      end else if (wr_cfg && !paddr[2]) begin
         async0 <= pwdata[0];
         dte0 <= pwdata[1];
         frc <= pwdata[1];
         lvl <= 1'b0;
      end else if (wr_lead) begin
         frc <= pwdata[3:2] != 2'h2;
         lvl <= pwdata[3:2] == 2'h1;
      end
   end
   property p_role(logic [1:0] code, logic h, logic s);
      wr_cfg && pwdata[3:2] == code && !(code == 2'h1 && pwdata[5:4] != 2'h0)
         |-> ##2 half_duplex[$past(paddr[2], 2)] == h
            && signalling_on[$past(paddr[2], 2)] == s;
   endproperty
   AST_ROLE_SLAVE: assert property (p_role(2'h2, 1'b1, 1'b0))
      else $error("slave role without half duplex and signalling off");
   AST_ROLE_MASTER: assert property (p_role(2'h1, 1'b0, 1'b0))
      else $error("master role without full duplex and signalling off");
   AST_ROLE_OFF: assert property (p_role(2'h0, 1'b0, 1'b1))
      else $error("disabled role did not restore duplex and signalling");
   AST_HALF_CAUSE: assert property (up == 2'h3 && $changed(half_duplex)
      |-> $past(wr_cfg) || $past(wr_cfg, 2))
      else $error("duplex changed without a role write");
   AST_DELAY_ROLE: assert property (wr_dly
      && !half_duplex[paddr[2]] |-> pslverr)
      else $error("delay write accepted on a non-slave circuit");
   AST_DELAY_RANGE: assert property (wr_dly
      && pwdata > 32'hE |-> pslverr)
      else $error("delay above 140 ms accepted");
   AST_CONNECTED_LOCK: assert property (acc_w && paddr[7:3] == 5'h0
      && connected[paddr[2]] |-> pslverr)
      else $error("mode write accepted while connected");
   AST_FORCED_CTS: assert property (up == 2'h3
      && $stable({frc, lvl, dte0}) && frc && !dte0 |-> pin_out[0].cts == lvl)
      else $error("forced CTS level not held");
   AST_DCE_DIRS: assert property (up == 2'h3 && $stable(dte0) && !dte0
      |-> pin_oe[0].cts && !pin_oe[0].rts)
      else $error("DCE lead directions wrong");
   AST_SYNC_UNUSED: assert property (up == 2'h3 && $stable(async0)
      && !async0 |-> !pin_oe[0].dtr && !pin_oe[0].dsr
      && !pin_out[0].dtr && !pin_out[0].dsr
      && !net_tx[0].dtr && !net_tx[0].dsr)
      else $error("DTR or DSR active in sync mode");
   COV_SLAVE: cover property (wr_cfg && pwdata[3:2] == 2'h2);
   COV_DELAY_REFUSED: cover property (wr_dly && pslverr);
   COV_FORCED: cover property (frc && lvl && pin_out[0].cts);
endmodule

bind scl_top scl_top_sva #(.STEP_CYCLES(STEP_CYCLES)) sva_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .connected(connected),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .net_rx(net_rx),
   .net_tx(net_tx), .half_duplex(half_duplex),
   .signalling_on(signalling_on)
);

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [1:0] connected = 2'h0;
   logic [1:0] half_duplex, signalling_on;
   scl_pkg::scl_leads_s [1:0] pin_in, pin_out, pin_oe, net_tx;
   scl_pkg::scl_leads_s [1:0] net_rx = '0;
   scl_pkg::scl_leads_s [1:0] want = '0;
   int bad_count = 0;
   int num_checks = 0;

   always #2 pclk = ~pclk;

   scl_top #(.STEP_CYCLES(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .connected(connected),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .net_rx(net_rx), .net_tx(net_tx), .half_duplex(half_duplex),
      .signalling_on(signalling_on)
   );
   scl_equip equip_u (
      .pclk(pclk), .pin_oe(pin_oe), .want(want), .pin_in(pin_in)
   );

   task automatic test_done;
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   function automatic logic [7:0] ad(input logic [7:0] ofs, input int c);
      return ofs + 8'(4 * c);
   endfunction

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] ex,
                      input logic ee, input logic [31:0] msk = 32'hFFFF_FFFF);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         test_done;
      end
      chk("pslverr", 32'(ee), 32'(pslverr));
      if (!w) begin
         chk("prdata", ex, prdata & msk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_reset;
      chk("half_duplex", 32'h0, half_duplex);
      chk("signalling_on", 32'h3, signalling_on);
      chk("pin_oe0", 32'h2, pin_oe[0]);
      acc(1'b0, scl_pkg::CFG_OFS, 32'h0, 32'h0, 1'b0);
      acc(1'b0, scl_pkg::DELAY_OFS, 32'h0, 32'h0, 1'b0);
      acc(1'b0, scl_pkg::LEAD_OFS, 32'h0, 32'h28, 1'b0);
      acc(1'b0, scl_pkg::MAP_END, 32'h0, 32'h0, 1'b1);
      acc(1'b1, scl_pkg::STAT_OFS, 32'h1, 32'h0, 1'b1);
   endtask

   task automatic t_lead;
      logic [31:0] cv [4] = '{32'h1, 32'h3, 32'h82, 32'h2};
      logic [31:0] dflt [4] = '{32'h268, 32'h1A2, 32'h20, 32'h22};
      logic [31:0] oe [4] = '{32'hA, 32'h14, 32'h4, 32'h4};
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, scl_pkg::CFG_OFS, cv[i], 32'h0, 1'b0);
         acc(1'b0, scl_pkg::LEAD_OFS, 32'h0, dflt[i], 1'b0);
         chk("pin_oe0", oe[i], pin_oe[0]);
      end
      acc(1'b1, scl_pkg::CFG_OFS, 32'h1, 32'h0, 1'b0);
      for (int c = 0; c < 6; c++) begin
         net_rx[0].cts <= c[0];
         acc(1'b1, scl_pkg::LEAD_OFS, 32'(c / 2) << 2, 32'h0, 1'b0);
         repeat (2) @(posedge pclk);
         chk("cts0", c < 2 ? 32'h0 : c < 4 ? 32'h1 : 32'(c[0]),
             pin_out[0].cts);
      end
      want[0].rts <= 1'b1;
      acc(1'b1, scl_pkg::LEAD_OFS, 32'h20, 32'h0, 1'b0);
      repeat (4) @(posedge pclk);
      chk("net_tx0_rts", 32'h1, net_tx[0].rts);
      acc(1'b1, scl_pkg::LEAD_OFS, 32'h400, 32'h0, 1'b1);
   endtask

   task automatic t_rate;
      logic [31:0] ex [3] = '{32'hA, 32'h2, 32'h0};
      net_rx[0] <= '1;
      for (int r = 0; r < 3; r++) begin
         acc(1'b1, scl_pkg::CFG_OFS, 32'(1 + 16 * r), 32'h0, 1'b0);
         acc(1'b1, scl_pkg::LEAD_OFS, 32'h2AA, 32'h0, 1'b0);
         repeat (2) @(posedge pclk);
         chk("out0", ex[r], pin_out[0] & pin_oe[0]);
      end
   endtask

   task automatic t_sync;
      want[0].rts <= 1'b0;
      acc(1'b1, scl_pkg::CFG_OFS, 32'h0, 32'h0, 1'b0);
      repeat (6) @(posedge pclk);
      want[0].rts <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("cts0", 32'h1, pin_out[0].cts);
      chk("dcd_tx0", 32'h1, net_tx[0].dcd);
      chk("rts_tx0", 32'h0, net_tx[0].rts);
      chk("dtr_dsr0", 32'h0, {pin_oe[0].dtr, pin_oe[0].dsr,
          net_tx[0].dtr, net_tx[0].dsr});
      want[0].rts <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("cts0", 32'h0, pin_out[0].cts);
   endtask

   task automatic t_slave;
      connected[1] <= 1'b1;
      acc(1'b1, ad(scl_pkg::CFG_OFS, 1), 32'h8, 32'h0, 1'b1);
      connected[1] <= 1'b0;
      acc(1'b1, ad(scl_pkg::DELAY_OFS, 1), 32'h3, 32'h0, 1'b1);
      acc(1'b1, ad(scl_pkg::CFG_OFS, 1), 32'h8, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk("role1", 32'h2, {half_duplex[1], signalling_on[1]});
      acc(1'b1, ad(scl_pkg::LEAD_OFS, 1), 32'h29, 32'h0, 1'b0);
      acc(1'b1, ad(scl_pkg::DELAY_OFS, 1), 32'hF, 32'h0, 1'b1);
      acc(1'b1, ad(scl_pkg::DELAY_OFS, 1), 32'hE, 32'h0, 1'b0);
      acc(1'b0, ad(scl_pkg::DELAY_OFS, 1), 32'h0, 32'hE, 1'b0);
      want[1].rts <= 1'b1;
      repeat (20) @(posedge pclk);
      acc(1'b0, ad(scl_pkg::STAT_OFS, 1), 32'h0, 32'h1000, 1'b0,
          32'h1000);
      chk("cts1", 32'h0, pin_out[1].cts);
      repeat (60) @(posedge pclk);
      acc(1'b0, ad(scl_pkg::STAT_OFS, 1), 32'h0, 32'h0, 1'b0,
          32'h1000);
      chk("cts1", 32'h1, pin_out[1].cts);
      acc(1'b1, ad(scl_pkg::CFG_OFS, 1), 32'h4, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk("role1", 32'h0, {half_duplex[1], signalling_on[1]});
      acc(1'b0, ad(scl_pkg::DELAY_OFS, 1), 32'h0, 32'h0, 1'b0);
      acc(1'b1, ad(scl_pkg::CFG_OFS, 1), 32'h0, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk("role1", 32'h1, {half_duplex[1], signalling_on[1]});
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_reset;
      t_lead;
      t_rate;
      t_sync;
      t_slave;
      test_done;
   end
endmodule
